// file: rtl/nsr_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Device keeps an 8-bit status byte about the last program or erase.
// [RULE2] After status command, device drives status once chip and read enables fall.
// [RULE3] Status refreshes while polling; host need not re-toggle enables.
// [RULE4] Each device answers only under its own chip and read enable.
// [RULE5] Device stays in status mode until another command arrives.
// [RULE6] Bit 7 high means unprotected, low means protected.
// [RULE7] In cache read, bit 6 shows cache register ready.
// [RULE8] Otherwise bit 6 shows engine ready.
// [RULE9] Bit 5 shows engine idle; equals bit 6 outside cache read.
// [RULE10] Bit 0 high means program or erase failed.
// [RULE11] Bits 4 to 1 are reserved; host ignores them.
// [RULE12] Signature: command 90h, address 00h, then four read cycles.
// [RULE13] Byte 3 holds chip count, cell levels, simultaneous pages fields.
// [RULE14] Byte 4 holds page, spare, block size and bus width fields.
// [RULE15] Byte 4 bits 7 and 3 give minimum sequential access time.
// [RULE16] Write protect low blocks program and erase; hold low at power edges.
// [RULE17] Program failure reports only bits that failed to go from 1 to 0.
// [RULE18] On finish, bit 6 goes to 1 and ready/busy goes high.
// [RULE19] Device drives reserved status bits as zero.
module nsr_host #(
   parameter int POLL_GAP = 2
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // User commands
   input wire logic i_status_req,
   input wire logic i_sig_req,
   input wire logic i_stop_poll,
   input wire logic i_wp_release,
   // User results
   output logic o_busy,
   output logic o_status_valid,
   output logic [7:0] o_status,
   output logic o_unprotected_flag,
   output logic o_engine_or_cache_ready_flag,
   output logic o_engine_idle_flag,
   output logic o_operation_fail_flag,
   output logic o_sig_valid,
   output logic [31:0] o_signature,
   output logic [1:0] o_chip_count_code,
   output logic [1:0] o_cell_level_code,
   output logic [1:0] o_page_prog_code,
   output logic [1:0] o_page_size_code,
   output logic o_spare_16,
   output logic [1:0] o_block_size_code,
   output logic o_bus_x16,
   output logic [1:0] o_access_time_code,
   output logic o_ready,
   // Device pins
   output logic o_chip_enable_n,
   output logic o_cmd_latch,
   output logic o_addr_latch,
   output logic o_write_enable_n,
   output logic o_read_enable_n,
   output logic o_write_protect_n,
   output logic [7:0] o_data_lines,
   output logic o_data_lines_oe_n,
   input wire logic [7:0] i_data_lines,
   input wire logic i_ready_busy_output
);
   if (POLL_GAP < 1 || POLL_GAP > 15) begin : g_gap_check
      $error("POLL_GAP must be 1 to 15");
   end

   typedef enum {
      IDLE,
      CMD,
      ADDR,
      SIG_RD,
      POLL_RD,
      POLL_GAP_W
   } nsr_state_type;

   // ***************
   // Pin synchronisers
   // ***************
   logic [7:0] data_s1, data_s2;
   logic rb_s1, rb_s2;
   always_ff @(posedge i_ref_clk) begin
      data_s1 <= i_data_lines;
      data_s2 <= data_s1;
      rb_s1 <= i_ready_busy_output;
      rb_s2 <= rb_s1;
   end

   // ***************
   // Bus sequencer
   // ***************
   nsr_state_type state, next_state;
   logic sig_mode, next_sig_mode;
   logic [1:0] byte_idx, next_byte_idx;
   logic [31:0] sig, next_sig;
   logic [7:0] status, next_status;
   logic status_valid, next_status_valid;
   logic sig_valid, next_sig_valid;
   logic [3:0] gap, next_gap;
   logic wp_n, next_wp_n;
   logic strb_start, strb_low, strb_sample, strb_done;

   nsr_strobe u_strobe (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_start(strb_start),
      .o_low(strb_low),
      .o_sample(strb_sample),
      .o_done(strb_done)
   );

   // Sample two cycles late to cover the pin synchroniser
   logic samp_d1, samp_d2;
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         samp_d1 <= 1'b0;
         samp_d2 <= 1'b0;
      end else begin
         samp_d1 <= strb_sample;
         samp_d2 <= samp_d1;
      end
   end

   always_comb begin
      next_state = state;
      next_sig_mode = sig_mode;
      next_byte_idx = byte_idx;
      next_sig = sig;
      next_status = status;
      next_status_valid = 1'b0;
      next_sig_valid = 1'b0;
      next_gap = gap;
      next_wp_n = wp_n | i_wp_release; // RULE16
      strb_start = 1'b0;
      unique case (state)
         IDLE: begin
            if (i_sig_req) begin
               next_sig_mode = 1'b1;
               next_state = CMD;
               strb_start = 1'b1;
            end else if (i_status_req) begin
               next_sig_mode = 1'b0;
               next_state = CMD;
               strb_start = 1'b1;
            end
         end
         CMD: begin
            if (strb_done) begin
               strb_start = 1'b1;
               next_byte_idx = 2'h0;
               next_state = sig_mode ? ADDR : POLL_RD; // RULE12
            end
         end
         ADDR: begin
            if (strb_done) begin
               strb_start = 1'b1;
               next_state = SIG_RD;
            end
         end
         SIG_RD: begin
            if (samp_d2) begin
               next_sig = {data_s2, sig[31:8]}; // RULE12
               if (byte_idx == 2'(nsr_pkg::SIG_BYTES - 1)) begin
                  next_sig_valid = 1'b1;
                  next_state = IDLE;
               end else begin
                  next_byte_idx = byte_idx + 2'h1;
                  strb_start = 1'b1;
               end
            end
         end
         POLL_RD: begin
            if (samp_d2) begin
               // Reserved bits masked off, whatever the device returns
               next_status = data_s2 & ~nsr_pkg::ST_RESERVED_MASK; // RULE11 RULE19
               next_status_valid = 1'b1;
               next_gap = 4'(POLL_GAP);
               next_state = POLL_GAP_W;
            end
         end
         POLL_GAP_W: begin
            // Device stays in status mode: no new command needed to re-read
            next_gap = gap - 4'h1;
            if (i_stop_poll) begin
               next_state = IDLE; // RULE5
            end else if (gap == 4'h1) begin
               strb_start = 1'b1;
               next_state = POLL_RD; // RULE3
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state <= IDLE;
         sig_mode <= 1'b0;
         byte_idx <= 2'h0;
         sig <= 32'h0;
         status <= 8'h00;
         status_valid <= 1'b0;
         sig_valid <= 1'b0;
         gap <= 4'h0;
         wp_n <= 1'b0;
      end else begin
         state <= next_state;
         sig_mode <= next_sig_mode;
         byte_idx <= next_byte_idx;
         sig <= next_sig;
         status <= next_status;
         status_valid <= next_status_valid;
         sig_valid <= next_sig_valid;
         gap <= next_gap;
         wp_n <= next_wp_n;
      end
   end

   // ***************
   // Registered pin and user outputs
   // ***************
   logic write_phase;
   always_comb begin
      write_phase = (state == CMD) || (state == ADDR);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_chip_enable_n <= 1'b1;
         o_cmd_latch <= 1'b0;
         o_addr_latch <= 1'b0;
         o_write_enable_n <= 1'b1;
         o_read_enable_n <= 1'b1;
         o_data_lines <= 8'h00;
         o_data_lines_oe_n <= 1'b1;
         o_write_protect_n <= 1'b0;
         o_busy <= 1'b0;
         o_ready <= 1'b0;
      end else begin
         o_chip_enable_n <= (next_state == IDLE); // RULE4
         o_cmd_latch <= (state == CMD);
         o_addr_latch <= (state == ADDR);
         o_write_enable_n <= ~(write_phase && strb_low);
         o_read_enable_n <= ~(((state == SIG_RD) || (state == POLL_RD)) && strb_low); // RULE2
         o_data_lines <= (state == ADDR) ? nsr_pkg::ADDR_SIGNATURE :
                         (sig_mode ? nsr_pkg::CMD_SIGNATURE : nsr_pkg::CMD_STATUS);
         o_data_lines_oe_n <= ~write_phase;
         o_write_protect_n <= wp_n; // RULE16
         o_busy <= (next_state != IDLE);
         o_ready <= rb_s2; // RULE18
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_status_valid <= 1'b0;
         o_status <= 8'h00;
         o_unprotected_flag <= 1'b0;
         o_engine_or_cache_ready_flag <= 1'b0;
         o_engine_idle_flag <= 1'b0;
         o_operation_fail_flag <= 1'b0;
         o_sig_valid <= 1'b0;
         o_signature <= 32'h0;
      end else begin
         o_status_valid <= status_valid;
         o_status <= status; // RULE1
         o_unprotected_flag <= status[nsr_pkg::ST_UNPROT]; // RULE6
         o_engine_or_cache_ready_flag <= status[nsr_pkg::ST_READY]; // RULE7 RULE8
         o_engine_idle_flag <= status[nsr_pkg::ST_IDLE]; // RULE9
         o_operation_fail_flag <= status[nsr_pkg::ST_FAIL]; // RULE10 RULE17
         o_sig_valid <= sig_valid;
         o_signature <= sig;
      end
   end

   // Field decode of the last signature, byte 1 in bits 7:0
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_chip_count_code <= 2'h0;
         o_cell_level_code <= 2'h0;
         o_page_prog_code <= 2'h0;
         o_page_size_code <= 2'h0;
         o_spare_16 <= 1'b0;
         o_block_size_code <= 2'h0;
         o_bus_x16 <= 1'b0;
         o_access_time_code <= 2'h0;
      end else begin
         o_chip_count_code <= sig[16 + nsr_pkg::B3_CHIPS_LO +: 2]; // RULE13
         o_cell_level_code <= sig[16 + nsr_pkg::B3_LEVELS_LO +: 2]; // RULE13
         o_page_prog_code <= sig[16 + nsr_pkg::B3_PAGES_LO +: 2]; // RULE13
         o_page_size_code <= sig[24 + nsr_pkg::B4_PAGE_LO +: 2]; // RULE14
         o_spare_16 <= sig[24 + nsr_pkg::B4_SPARE]; // RULE14
         o_block_size_code <= sig[24 + nsr_pkg::B4_BLOCK_LO +: 2]; // RULE14
         o_bus_x16 <= sig[24 + nsr_pkg::B4_WIDTH]; // RULE14
         o_access_time_code <= {sig[24 + nsr_pkg::B4_TACC_HI],
                                sig[24 + nsr_pkg::B4_TACC_LO]}; // RULE15
      end
   end
endmodule

// file: rtl/nsr_pkg.sv
package nsr_pkg;
   // Command and address codes, signature length
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_SIGNATURE = 8'h90;
   localparam logic [7:0] ADDR_SIGNATURE = 8'h00;
   localparam int SIG_BYTES = 4;
   // Status byte fields
   localparam int ST_UNPROT = 7;
   localparam int ST_READY = 6;
   localparam int ST_IDLE = 5;
   localparam int ST_FAIL = 0;
   localparam logic [7:0] ST_RESERVED_MASK = 8'h1E;
   // Signature byte 3 fields
   localparam int B3_CHIPS_LO = 0;
   localparam int B3_LEVELS_LO = 2;
   localparam int B3_PAGES_LO = 4;
   // Signature byte 4 fields
   localparam int B4_PAGE_LO = 0;
   localparam int B4_SPARE = 2;
   localparam int B4_TACC_LO = 3;
   localparam int B4_BLOCK_LO = 4;
   localparam int B4_WIDTH = 6;
   localparam int B4_TACC_HI = 7;
   // Strobe timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int STROBE_LOW_NS = 50;
   localparam int STROBE_HIGH_NS = 30;
   localparam int STROBE_LOW_CYC =
      (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_HIGH_CYC =
      (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

   typedef enum {
      PH_IDLE,
      PH_LOW,
      PH_HIGH
   } nsr_phase_type;

   typedef enum {
      CY_CMD,
      CY_ADDR,
      CY_READ
   } nsr_cycle_type;
endpackage

// file: rtl/nsr_strobe.sv
`timescale 1ns/1ps
// One bus cycle: drive low for the low time, then high for the recovery time
module nsr_strobe (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Control
   input wire logic i_start,
   // Status
   output logic o_low,
   output logic o_sample,
   output logic o_done
);
   nsr_pkg::nsr_phase_type phase, next_phase;
   logic [nsr_pkg::CNT_W-1:0] cnt, next_cnt;
   // One start seen mid-cycle is kept so the next cycle follows back-to-back; a second one in the same cycle is lost
   logic pend, next_pend;

   always_comb begin
      next_phase = phase;
      next_cnt = cnt;
      next_pend = pend;
      o_sample = 1'b0;
      o_done = 1'b0;
      unique case (phase)
         nsr_pkg::PH_IDLE: begin
            next_pend = 1'b0;
            if (i_start) begin
               next_phase = nsr_pkg::PH_LOW;
               next_cnt = nsr_pkg::CNT_W'(nsr_pkg::STROBE_LOW_CYC);
            end
         end
         nsr_pkg::PH_LOW: begin
            next_cnt = cnt - nsr_pkg::CNT_ONE;
            if (i_start) begin
               next_pend = 1'b1;
            end
            if (cnt == nsr_pkg::CNT_ONE) begin
               o_sample = 1'b1;
               next_phase = nsr_pkg::PH_HIGH;
               next_cnt = nsr_pkg::CNT_W'(nsr_pkg::STROBE_HIGH_CYC);
            end
         end
         nsr_pkg::PH_HIGH: begin
            next_cnt = cnt - nsr_pkg::CNT_ONE;
            if (i_start) begin
               next_pend = 1'b1;
            end
            if (cnt == nsr_pkg::CNT_ONE) begin
               o_done = 1'b1;
               if (i_start || pend) begin
                  next_pend = 1'b0;
                  next_phase = nsr_pkg::PH_LOW;
                  next_cnt = nsr_pkg::CNT_W'(nsr_pkg::STROBE_LOW_CYC);
               end else begin
                  next_phase = nsr_pkg::PH_IDLE;
                  next_cnt = nsr_pkg::CNT_ZERO;
               end
            end
         end
      endcase
   end

   assign o_low = (phase == nsr_pkg::PH_LOW);

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         phase <= nsr_pkg::PH_IDLE;
         cnt <= nsr_pkg::CNT_ZERO;
         pend <= 1'b0;
      end else begin
         phase <= next_phase;
         cnt <= next_cnt;
         pend <= next_pend;
      end
   end
endmodule

// file: tb/nsr_host_monitor.sv
`timescale 1ns/1ps
// ****
// Host port checks
// ****
module nsr_host_monitor #(
   parameter int POLL_GAP = 2
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_sig_req,
   input wire logic o_busy,
   input wire logic o_status_valid,
   input wire logic [7:0] o_status,
   input wire logic o_unprotected_flag,
   input wire logic o_engine_or_cache_ready_flag,
   input wire logic o_operation_fail_flag,
   input wire logic o_sig_valid,
   input wire logic [31:0] o_signature,
   input wire logic [1:0] o_chip_count_code,
   input wire logic [1:0] o_page_size_code,
   input wire logic [1:0] o_access_time_code,
   input wire logic o_chip_enable_n,
   input wire logic o_cmd_latch,
   input wire logic o_addr_latch,
   input wire logic o_read_enable_n,
   input wire logic o_write_protect_n,
   input wire logic [7:0] o_data_lines
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   property p_resv; o_status_valid |-> o_status[4:1] == 4'h0; endproperty
   a_resv: assert property (p_resv) else $error("reserved status bits set");
   property p_flags;
      o_status_valid |=> o_unprotected_flag == $past(o_status[7])
         && o_engine_or_cache_ready_flag == $past(o_status[6])
         && o_operation_fail_flag == $past(o_status[0]);
   endproperty
   a_flags: assert property (p_flags) else $error("status flags differ");
   // Protect is sticky once raised, cleared only by reset
   property p_wp; !$past(i_reset) && $past(o_write_protect_n) |-> o_write_protect_n; endproperty
   a_wp: assert property (p_wp) else $error("write protect dropped");
   property p_sig;
      o_sig_valid |=> o_chip_count_code == $past(o_signature[17:16])
         && o_page_size_code == $past(o_signature[25:24])
         && o_access_time_code == {$past(o_signature[31]), $past(o_signature[27])};
   endproperty
   a_sig: assert property (p_sig) else $error("signature decode wrong");
   property p_sel; !o_read_enable_n |-> !o_chip_enable_n; endproperty
   a_sel: assert property (p_sel) else $error("read without select");
   property p_rlen; $fell(o_read_enable_n) |-> !o_read_enable_n [*5]; endproperty
   a_rlen: assert property (p_rlen) else $error("read strobe short");
   property p_cmd; o_cmd_latch |-> o_data_lines == 8'h70 || o_data_lines == 8'h90; endproperty
   a_cmd: assert property (p_cmd) else $error("bad command code");
   property p_addr; o_addr_latch |-> o_data_lines == 8'h00 && !o_cmd_latch; endproperty
   a_addr: assert property (p_addr) else $error("bad address cycle");
   property p_take; !o_busy && i_sig_req |=> o_busy; endproperty
   a_take: assert property (p_take) else $error("request not taken");
endmodule

// file: tb/nsr_dev_model.sv
`timescale 1ns/1ps
// ****
// Behavioural flash device
// ****
module nsr_dev_model #(
   parameter logic [7:0] MAKER = 8'hA5, // Arbitrary value
   parameter logic [7:0] PART = 8'h3C // Arbitrary value
) (
   // Pins from host
   input wire logic i_ce_n,
   input wire logic i_cl,
   input wire logic i_we_n,
   input wire logic i_re_n,
   input wire logic i_wp_n,
   input wire logic i_oe_n,
   input wire logic [7:0] i_host_d,
   // Internal state
   input wire logic i_busy,
   input wire logic i_cache,
   input wire logic i_fail,
   input wire logic [15:0] i_geom,
   // Pins to host, and command count for the testbench
   output logic [7:0] o_wire,
   output logic o_rb,
   output int o_ncmd
);
   logic [7:0] cmd = 8'h00;
   logic [7:0] last = 8'h00;
   logic [7:0] val;
   logic [31:0] sig;
   int idx = 0;
   initial o_ncmd = 0;
   // Sample mid-strobe: data may move at the rising edge
   always @(negedge i_we_n) begin
      #20;
      if (!i_ce_n && i_cl) begin
         cmd = i_host_d;
         idx = 0;
         o_ncmd++;
      end
   end
   always @(posedge i_re_n) begin
      last = val;
      if (idx < 3) idx++;
   end
   assign sig = {i_geom, PART, MAKER};
   // Reserved bits non-zero on purpose; host must mask
   always_comb begin
      if (cmd == 8'h90) val = sig[idx*8 +: 8];
      else val = {i_wp_n, i_cache | ~i_busy, ~i_busy, 4'hA, i_fail};
   end
   // Released bus shows the inverse of the last value
   assign o_wire = !i_oe_n ? i_host_d : (!i_ce_n && !i_re_n) ? val : ~last;
   assign o_rb = ~i_busy;
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
   localparam int POLL_GAP = 2;
   localparam logic [7:0] MK = 8'hA5; // Arbitrary value
   localparam logic [7:0] PT = 8'h3C; // Arbitrary value
   logic i_ref_clk = 0, i_reset = 1, i_status_req = 0, i_sig_req = 0;
   logic i_stop_poll = 0, i_wp_release = 0, busy = 1, cache = 0, fail = 0;
   logic [15:0] geom = 16'h0000;
   logic o_busy, o_status_valid, o_unprotected_flag, o_engine_or_cache_ready_flag;
   logic o_engine_idle_flag, o_operation_fail_flag, o_sig_valid, o_spare_16, o_bus_x16;
   logic o_ready, o_chip_enable_n, o_cmd_latch, o_addr_latch, o_write_enable_n;
   logic o_read_enable_n, o_write_protect_n, o_data_lines_oe_n, i_ready_busy_output;
   logic [7:0] o_status, o_data_lines, i_data_lines;
   logic [31:0] o_signature;
   logic [1:0] o_chip_count_code, o_cell_level_code, o_page_prog_code, o_page_size_code;
   logic [1:0] o_block_size_code, o_access_time_code;
   int miscompares = 0, check_count = 0, cycles = 0, ncmd;
   nsr_host #(.POLL_GAP(POLL_GAP)) nsr_host_inst (
      .i_ref_clk, .i_reset, .i_status_req, .i_sig_req, .i_stop_poll, .i_wp_release,
      .o_busy, .o_status_valid, .o_status, .o_unprotected_flag,
      .o_engine_or_cache_ready_flag, .o_engine_idle_flag, .o_operation_fail_flag,
      .o_sig_valid, .o_signature, .o_chip_count_code, .o_cell_level_code,
      .o_page_prog_code, .o_page_size_code, .o_spare_16, .o_block_size_code,
      .o_bus_x16, .o_access_time_code, .o_ready, .o_chip_enable_n, .o_cmd_latch,
      .o_addr_latch, .o_write_enable_n, .o_read_enable_n, .o_write_protect_n,
      .o_data_lines, .o_data_lines_oe_n, .i_data_lines, .i_ready_busy_output
   );
   nsr_dev_model #(.MAKER(MK), .PART(PT)) nsr_dev_model_inst (
      .i_ce_n(o_chip_enable_n), .i_cl(o_cmd_latch), .i_we_n(o_write_enable_n),
      .i_re_n(o_read_enable_n), .i_wp_n(o_write_protect_n), .i_oe_n(o_data_lines_oe_n),
      .i_host_d(o_data_lines), .i_busy(busy), .i_cache(cache), .i_fail(fail),
      .i_geom(geom), .o_wire(i_data_lines), .o_rb(i_ready_busy_output), .o_ncmd(ncmd)
   );
   initial forever #5 i_ref_clk = ~i_ref_clk;
   // Cut a hang short
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic req(input bit s);
      if (s) i_sig_req = 1;
      else i_status_req = 1;
      @(negedge i_ref_clk);
      i_sig_req = 0;
      i_status_req = 0;
   endtask
   task automatic wait_res(input bit s);
      int n = 0;
      // Look at the falling edge, where the one-cycle valid pulse has settled
      do begin
         @(negedge i_ref_clk);
         n++;
      end while (!(s ? o_sig_valid : o_status_valid) && n < 400);
      `CHK(n < 400, 1'b1)
   endtask
   task automatic stop_poll();
      int n = 0;
      i_stop_poll = 1;
      while (o_busy && n < 400) begin
         @(negedge i_ref_clk);
         n++;
      end
      i_stop_poll = 0;
      `CHK(o_busy, 1'b0)
   endtask
   task automatic t_poll();
      req(0);
      wait_res(0);
      `CHK(o_status, 8'h00)
      busy = 0;
      repeat (3) wait_res(0);
      `CHK(o_status, 8'h60)
      `CHK(o_engine_or_cache_ready_flag, 1'b1)
      `CHK(o_ready, 1'b1)
      `CHK(ncmd, 1)
      stop_poll();
   endtask
   task automatic t_cache_fail();
      i_wp_release = 1;
      @(negedge i_ref_clk);
      i_wp_release = 0;
      cache = 1;
      busy = 1;
      fail = 1;
      req(0);
      repeat (3) wait_res(0);
      `CHK(o_status, 8'hC1)
      `CHK(o_unprotected_flag, 1'b1)
      `CHK(o_engine_idle_flag, 1'b0)
      `CHK(o_operation_fail_flag, 1'b1)
      stop_poll();
   endtask
   task automatic t_sig();
      logic [15:0] tbl [2] = '{16'hE51B, 16'h2824};
      for (int k = 0; k < 2; k++) begin
         geom = tbl[k];
         req(1);
         wait_res(1);
         `CHK(o_signature, {geom, PT, MK})
         `CHK(o_chip_count_code, geom[1:0])
         `CHK(o_cell_level_code, geom[3:2])
         `CHK(o_page_prog_code, geom[5:4])
         `CHK(o_page_size_code, geom[9:8])
         `CHK(o_spare_16, geom[10])
         `CHK(o_block_size_code, geom[13:12])
         `CHK(o_bus_x16, geom[14])
         `CHK(o_access_time_code, {geom[15], geom[11]})
      end
   endtask
   initial begin
      repeat (3) @(negedge i_ref_clk);
      i_reset = 0;
      `CHK(o_write_protect_n, 1'b0)
      `CHK(o_chip_enable_n, 1'b1)
      `CHK(o_data_lines_oe_n, 1'b1)
      t_poll();
      t_cache_fail();
      t_sig();
      // Status after signature needs a fresh command
      req(0);
      wait_res(0);
      `CHK(o_status, 8'hC1)
      stop_poll();
      print_verdict();
   end
endmodule
bind nsr_host nsr_host_monitor #(.POLL_GAP(POLL_GAP)) nsr_host_monitor_inst (
   .i_ref_clk, .i_reset, .i_sig_req, .o_busy, .o_status_valid, .o_status,
   .o_unprotected_flag, .o_engine_or_cache_ready_flag, .o_operation_fail_flag,
   .o_sig_valid, .o_signature, .o_chip_count_code, .o_page_size_code,
   .o_access_time_code, .o_chip_enable_n, .o_cmd_latch, .o_addr_latch,
   .o_read_enable_n, .o_write_protect_n, .o_data_lines
);
